// ==== hw/pdmc_entry_delay.sv ====
// counts the fixed delay from field write to clock gating
`timescale 1ns/100ps
module pdmc_entry_delay
  import pdmc_pkg::*;
(
  input  wire logic clk,
  input  wire logic rstN,
  input  wire logic ce,
  input  wire logic start,
  input  wire logic cancel,
  output logic      done
);
  logic [3:0] cnt_q;
  logic       busy_q;

  // done pulses on the eighth cycle after start
  assign done = busy_q && (cnt_q == PDMC_ENTRY_DELAY - 4'h1);

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      cnt_q  <= 4'h0;
      busy_q <= 1'b0;
    end else if (ce) begin
      if (cancel || done) begin
        busy_q <= 1'b0;
        cnt_q  <= 4'h0;
      end else if (start) begin
        busy_q <= 1'b1;
        cnt_q  <= 4'h0;
      end else if (busy_q) begin
        cnt_q <= cnt_q + 4'h1;
      end
    end
  end
endmodule

// ==== hw/pdmc_pkg.sv ====
// package for the power-down mode controller
// Notes on behaviour
// - clock-gating mode takes effect eight to nine cycles after the field write
// - non-enabled interrupt wake resumes at the halted instruction, no service
// - enabled interrupt wake runs the service routine, then resumes
// - both PLL-stop modes leave only through device reset, never interrupts
// - field 001001 selects clock gating, woken only by an enabled interrupt
// - field 010001 selects clock gating, woken by any interrupt
// - clock gating blocks the CPU clock while interrupt logic keeps running
// - dma transfer engine keeps working during clock gating
// - field 011010 halts the PLL output clock, state is kept
// - field 011100 stops PLL input clock; after reset wait for PLL lock
// - in PLL-stop modes functional outputs hold their last state
// - attached emulator masks power-down until it resets or detaches
// - in PLL-stop modes emulation step or run spins idle, PC writes fail
// - field sits in bits 15..10; 14 any wake, 13 enabled wake, 12..10 modes
package pdmc_pkg;
  // ****************************************************************
  // field layout and codes
  // ****************************************************************
  localparam int PDMC_FIELD_LSB = 10;
  localparam int PDMC_FIELD_MSB = 15;
  localparam logic [15:0] PDMC_CSR_ADDR = 16'h0000;
  localparam logic [5:0] PDMC_FIELD_RESET  = 6'h00;
  localparam logic [5:0] PDMC_CODE_GATE_EN = 6'h09;
  localparam logic [5:0] PDMC_CODE_GATE_ANY = 6'h11;
  localparam logic [5:0] PDMC_CODE_PLL_OUT = 6'h1a;
  localparam logic [5:0] PDMC_CODE_PLL_IN  = 6'h1c;
  localparam logic [3:0] PDMC_ENTRY_DELAY  = 4'h8;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [2:0] {
    PDMC_RUN      = 3'b000,
    PDMC_ARM      = 3'b001,
    PDMC_GATED    = 3'b010,
    PDMC_PLL_OUT  = 3'b011,
    PDMC_PLL_IN   = 3'b100,
    PDMC_RELOCK   = 3'b101
  } pdmc_state_t;

  typedef struct packed {
    logic intrEnabled;
    logic intrAny;
  } pdmc_wake_t;

  typedef struct packed {
    logic cpuClkEn;
    logic pllOutStop;
    logic pllInStop;
    logic ioFreeze;
    logic serviceIsr;
  } pdmc_ctl_t;
endpackage

// ==== hw/pdmc_top.sv ====
// power-down mode controller: field, mode sequencing and clock gates
//
// Our own choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/100ps
module pdmc_top
  import pdmc_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        arst_n,
  input  wire logic        clkEn,
  input  wire logic [15:0] regAddr,
  input  wire logic [31:0] regWrData,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic      [31:0] regRdData,
  input  wire logic        intrPending,
  input  wire logic        intrEnabled,
  input  wire logic        emuAttached,
  input  wire logic        pllLocked,
  input  wire logic        emuRunReq,
  input  wire logic        emuPcWrReq,
  output logic             cpuClkEn,
  output logic             intLogicClkEn,
  output logic             dmaClkEn,
  output logic             pllOutStop,
  output logic             pllInStop,
  output logic             ioFreeze,
  output logic             serviceIsr,
  output logic             emuSpinIdle,
  output logic             emuPcWrFail,
  output logic             cpuReady
);
  // ****************************************************************
  // reset synchroniser
  // ****************************************************************
  logic rstMeta_q;
  logic rstN;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rstMeta_q <= 1'b0;
      rstN      <= 1'b0;
    end else begin
      rstMeta_q <= 1'b1;
      rstN      <= rstMeta_q;
    end
  end

  // ****************************************************************
  // register port: control-status word, field only
  // ****************************************************************
  logic [5:0]  field_q;
  logic [5:0]  field_d;
  logic        fieldWr;
  logic        csrHit;
  logic [31:0] rdWord;
  pdmc_state_t state_q;
  pdmc_state_t state_d;

  function automatic logic isGate(input logic [5:0] f);
    return (f == PDMC_CODE_GATE_EN) || (f == PDMC_CODE_GATE_ANY);
  endfunction

  assign csrHit  = (regAddr == PDMC_CSR_ADDR);
  assign fieldWr = regWr && csrHit;
  // bits 15..10 hold the field; the rest of the word reads as zero
  assign field_d = regWrData[PDMC_FIELD_MSB:PDMC_FIELD_LSB];
  assign rdWord  = csrHit ?
                   {16'h0000, field_q, 10'h000} : 32'h0000_0000;

  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      regRdData <= 32'h0000_0000;
    end else if (clkEn) begin
      regRdData <= regRd ? rdWord : 32'h0000_0000;
    end
  end

  // field auto-clears once the CPU wakes, like a one-shot request
  logic wakeNow;

  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      field_q <= PDMC_FIELD_RESET;
    end else if (clkEn) begin
      if (fieldWr) begin
        field_q <= field_d;
      end else if (wakeNow) begin
        field_q <= PDMC_FIELD_RESET;
      end
    end
  end

  // ****************************************************************
  // mode decode and entry delay
  // ****************************************************************
  logic armStart;
  logic armDone;
  logic anyWake;
  logic enWake;
  logic inhibit;
  pdmc_wake_t wake;

  // emulator presence masks every programmed mode
  assign inhibit  = emuAttached;
  assign armStart = fieldWr && isGate(field_d) && !inhibit;
  assign wake     = '{intrEnabled: intrPending && intrEnabled,
                      intrAny:     intrPending};
  assign enWake   = wake.intrEnabled;
  assign anyWake  = (field_q == PDMC_CODE_GATE_ANY) ?
                    wake.intrAny : enWake;
  assign wakeNow  = (state_q == PDMC_GATED) && anyWake;

  // write lands in cycle 0; gating starts after eight more cycles
  pdmc_entry_delay u_delay (
    .clk    (clk_sys),
    .rstN   (rstN),
    .ce     (clkEn),
    .start  (armStart),
    .cancel (inhibit || (fieldWr && !isGate(field_d))),
    .done   (armDone)
  );

  // ****************************************************************
  // mode state machine
  // ****************************************************************
  always_comb begin
    state_d = state_q;
    case (state_q)
      PDMC_RUN: begin
        if (fieldWr && !inhibit) begin
          if (isGate(field_d)) begin
            state_d = PDMC_ARM;
          end else if (field_d == PDMC_CODE_PLL_OUT) begin
            state_d = PDMC_PLL_OUT;
          end else if (field_d == PDMC_CODE_PLL_IN) begin
            state_d = PDMC_PLL_IN;
          end
        end
        // zero and reserved codes stay here
      end
      PDMC_ARM: begin
        if (inhibit || (fieldWr && !isGate(field_d))) begin
          state_d = PDMC_RUN;
        end else if (armDone) begin
          state_d = PDMC_GATED;
        end
      end
      PDMC_GATED: begin
        if (inhibit || anyWake) begin
          state_d = PDMC_RUN;
        end
      end
      // only the device reset leaves these
      PDMC_PLL_OUT: state_d = PDMC_PLL_OUT;
      PDMC_PLL_IN:  state_d = PDMC_PLL_IN;
      PDMC_RELOCK: begin
        if (pllLocked) begin
          state_d = PDMC_RUN;
        end
      end
      default: state_d = PDMC_RUN;
    endcase
  end

  // remembers that the last reset woke from the input-stop mode;
  // survives the device reset, cleared only by the same lock wait
  logic relockNeed_q;
  logic seenReset_q;

  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      state_q     <= PDMC_RUN;
      seenReset_q <= 1'b0;
    end else if (clkEn) begin
      seenReset_q <= 1'b1;
      if (!seenReset_q && relockNeed_q) begin
        state_q <= PDMC_RELOCK;
      end else begin
        state_q <= state_d;
      end
    end
  end

  // not reset by the device reset: it carries across the wake-up
  always_ff @(posedge clk_sys) begin
    if (clkEn) begin
      if (state_q == PDMC_PLL_IN) begin
        relockNeed_q <= 1'b1;
      end else if (state_q == PDMC_RELOCK && pllLocked) begin
        relockNeed_q <= 1'b0;
      end else if (!seenReset_q && !relockNeed_q) begin
        relockNeed_q <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  logic      isrPend_q;
  pdmc_ctl_t ctl;
  logic      pllStop;

  assign pllStop = (state_q == PDMC_PLL_OUT) || (state_q == PDMC_PLL_IN);

  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      isrPend_q <= 1'b0;
    end else if (clkEn) begin
      // enabled interrupt: service first, then resume
      isrPend_q <= wakeNow && enWake;
    end
  end

  assign ctl.cpuClkEn   = (state_q != PDMC_GATED) && !pllStop &&
                          (state_q != PDMC_RELOCK);
  assign ctl.pllOutStop = (state_q == PDMC_PLL_OUT);
  assign ctl.pllInStop  = (state_q == PDMC_PLL_IN);
  assign ctl.ioFreeze   = pllStop;
  assign ctl.serviceIsr = isrPend_q;

  assign cpuClkEn      = ctl.cpuClkEn;
  assign pllOutStop    = ctl.pllOutStop;
  assign pllInStop     = ctl.pllInStop;
  assign ioFreeze      = ctl.ioFreeze;
  assign serviceIsr    = ctl.serviceIsr;
  assign intLogicClkEn = !pllStop;
  assign dmaClkEn      = !pllStop;
  assign emuSpinIdle   = pllStop && emuRunReq;
  assign emuPcWrFail   = pllStop && emuPcWrReq;
  // held low one more edge so a pending relock cannot glitch it high
  assign cpuReady      = rstN && seenReset_q &&
                         (state_q != PDMC_RELOCK);

  // ****************************************************************
  // checks
  // ****************************************************************
  sequence s_gateWrite;
    fieldWr && isGate(field_d) && !inhibit && state_q == PDMC_RUN;
  endsequence

  sequence s_quietWait;
    (!inhibit && !fieldWr && clkEn) [*8];
  endsequence

  a_gate_entry_time: assert property (
    @(posedge clk_sys) disable iff (!rstN)
    s_gateWrite ##1 s_quietWait |=> !cpuClkEn)
    else $error("clock gating not entered on time");

  a_gate_not_early: assert property (
    @(posedge clk_sys) disable iff (!rstN)
    s_gateWrite |=> cpuClkEn [*7])
    else $error("clock gating entered too early");

  a_pll_stop_held: assert property (
    @(posedge clk_sys) disable iff (!rstN)
    pllStop |=> pllStop)
    else $error("PLL stop mode left without reset");

  a_gate_any_wake: assert property (
    @(posedge clk_sys) disable iff (!rstN)
    (state_q == PDMC_GATED && field_q == PDMC_CODE_GATE_ANY &&
     intrPending && clkEn) |=> cpuClkEn)
    else $error("any interrupt did not wake");

  a_gate_en_only: assert property (
    @(posedge clk_sys) disable iff (!rstN)
    (state_q == PDMC_GATED && field_q == PDMC_CODE_GATE_EN &&
     !intrEnabled && !inhibit) |=> !cpuClkEn)
    else $error("non-enabled interrupt woke enabled-only mode");

  a_isr_after_wake: assert property (
    @(posedge clk_sys) disable iff (!rstN)
    (wakeNow && enWake && clkEn) |=> serviceIsr && cpuClkEn)
    else $error("enabled wake did not request service");

  a_no_isr_plain: assert property (
    @(posedge clk_sys) disable iff (!rstN)
    (wakeNow && !enWake && clkEn) |=> !serviceIsr)
    else $error("non-enabled wake requested service");

  a_freeze_in_stop: assert property (
    @(posedge clk_sys) disable iff (!rstN)
    pllStop |-> ioFreeze && !cpuClkEn && emuSpinIdle == emuRunReq)
    else $error("outputs not frozen in PLL stop");

  a_emu_masks_mode: assert property (
    @(posedge clk_sys) disable iff (!rstN)
    (emuAttached && state_q == PDMC_RUN) |=> !pllStop &&
    state_q != PDMC_GATED)
    else $error("power-down entered with emulator attached");

  a_reserved_runs: assert property (
    @(posedge clk_sys) disable iff (!rstN)
    (fieldWr && clkEn && state_q == PDMC_RUN && !isGate(field_d) &&
     field_d != PDMC_CODE_PLL_OUT && field_d != PDMC_CODE_PLL_IN)
    |=> state_q == PDMC_RUN && cpuClkEn)
    else $error("reserved code applied a mode");

  a_ready_waits_lock: assert property (
    @(posedge clk_sys) disable iff (!rstN)
    (state_q == PDMC_RELOCK && !pllLocked) |=> !cpuReady)
    else $error("cpu released before PLL lock");

  a_arm_frozen: assert property (
    @(posedge clk_sys) disable iff (!rstN)
    (state_q == PDMC_ARM && !clkEn) |=> state_q == PDMC_ARM)
    else $error("entry delay ran while clock enable was low");
endmodule

// ==== verif/pdmc_cpu_model.sv ====
// cpu-side model: interrupt source and pll lock behind the controller
`timescale 1ns/100ps
module pdmc_cpu_model #(
  parameter int LOCK_CYC = 20
) (
  input  wire logic clk,
  input  wire logic raise,
  input  wire logic enIn,
  input  wire logic cpuClkEn,
  input  wire logic pllInStop,
  output logic      intrPending,
  output logic      intrEnabled,
  output logic      pllLocked
);
  int lockCnt = LOCK_CYC;
  initial begin
    intrPending = 1'b0;
    intrEnabled = 1'b0;
  end
  // a pending request is only taken once the cpu clock runs again
  always @(posedge clk) begin
    if (raise) begin
      intrPending <= 1'b1;
      intrEnabled <= enIn;
    end else if (cpuClkEn) begin
      intrPending <= 1'b0;
    end
  end
  // lock is lost while the input clock stops and needs time to return
  always @(posedge clk) begin
    if (pllInStop) begin
      lockCnt <= 0;
    end else if (lockCnt < LOCK_CYC) begin
      lockCnt <= lockCnt + 1;
    end
  end
  assign pllLocked = (lockCnt >= LOCK_CYC);
endmodule

// ==== verif/pdmc_tb_top.sv ====
// self-checking bench of the power-down mode controller
`timescale 1ns/100ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin \
  failures++; $display("Error at %0t: got %h want %h", $time, a, b); \
  end end
module pdmc_tb_top
  import pdmc_pkg::*;
;
  logic        clk_sys, arst_n, regWr, regRd, raise, enIn, clkEn;
  logic        emuAttached, emuRunReq, emuPcWrReq, cpuClkEn;
  logic [15:0] regAddr;
  logic [31:0] regWrData, regRdData, d;
  logic        intrPending, intrEnabled, pllLocked, intLogicClkEn;
  logic        dmaClkEn, pllOutStop, pllInStop, ioFreeze, serviceIsr;
  logic        emuSpinIdle, emuPcWrFail, cpuReady, woke, isr;
  logic [5:0]  f;
  int          failures, comparisons, n;
  logic [5:0]  codes [2] = '{PDMC_CODE_GATE_EN, PDMC_CODE_GATE_ANY};

  pdmc_top u_dut (.clk_sys(clk_sys), .arst_n(arst_n), .clkEn(clkEn),
    .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
    .regRd(regRd), .regRdData(regRdData), .intrPending(intrPending),
    .intrEnabled(intrEnabled), .emuAttached(emuAttached),
    .pllLocked(pllLocked), .emuRunReq(emuRunReq),
    .emuPcWrReq(emuPcWrReq), .cpuClkEn(cpuClkEn),
    .intLogicClkEn(intLogicClkEn), .dmaClkEn(dmaClkEn),
    .pllOutStop(pllOutStop), .pllInStop(pllInStop), .ioFreeze(ioFreeze),
    .serviceIsr(serviceIsr), .emuSpinIdle(emuSpinIdle),
    .emuPcWrFail(emuPcWrFail), .cpuReady(cpuReady));
  pdmc_cpu_model u_cpu (.clk(clk_sys), .raise(raise), .enIn(enIn),
    .cpuClkEn(cpuClkEn), .pllInStop(pllInStop),
    .intrPending(intrPending), .intrEnabled(intrEnabled),
    .pllLocked(pllLocked));

  // ****************************************************************
  // expectations
  // ****************************************************************
  function automatic logic wakes(logic [5:0] c, logic e);
    return e || (c == PDMC_CODE_GATE_ANY);
  endfunction

  // ****************************************************************
  // drivers
  // ****************************************************************
  task automatic test_done();
    if (failures == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic wr(input logic [15:0] a, input logic [5:0] c);
    @(posedge clk_sys);
    regAddr   <= a;
    regWrData <= {16'h0000, c, 10'h000};
    regWr     <= 1'b1;
    @(posedge clk_sys);
    regWr     <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a);
    @(posedge clk_sys);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge clk_sys);
    regRd   <= 1'b0;
    #1 d = regRdData;
  endtask
  task automatic irq(input logic e);
    @(posedge clk_sys);
    raise <= 1'b1;
    enIn  <= e;
    @(posedge clk_sys);
    raise <= 1'b0;
    woke = 1'b0;
    isr  = 1'b0;
    repeat (6) begin
      @(posedge clk_sys);
      #1 woke = woke | (cpuClkEn === 1'b1);
      isr = isr | (serviceIsr === 1'b1);
    end
  endtask
  task automatic do_reset();
    @(posedge clk_sys);
    arst_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
  endtask
  task automatic stop_test(input logic [5:0] c);
    wr(16'h0000, c);
    repeat (2) @(posedge clk_sys);
    emuRunReq  <= 1'b1;
    emuPcWrReq <= 1'b1;
    irq(1'b1);
    `CHK(pllOutStop, c == PDMC_CODE_PLL_OUT)
    `CHK(pllInStop, c == PDMC_CODE_PLL_IN)
    `CHK(cpuClkEn, 1'b0)
    `CHK(ioFreeze, 1'b1)
    `CHK({intLogicClkEn, dmaClkEn}, 2'b00)
    `CHK({emuSpinIdle, emuPcWrFail}, 2'b11)
    emuRunReq  <= 1'b0;
    emuPcWrReq <= 1'b0;
    do_reset();
    #1 `CHK({pllOutStop, pllInStop}, 2'b00)
    if (c == PDMC_CODE_PLL_IN) begin
      `CHK(cpuReady, 1'b0)
      n = 0;
      while (pllLocked !== 1'b1 && n < 60) begin
        @(posedge clk_sys);
        n++;
      end
      repeat (3) @(posedge clk_sys);
    end
    #1 `CHK(cpuReady, 1'b1)
  endtask

  // ****************************************************************
  // sequence
  // ****************************************************************
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    failures++;
    test_done();
  end
  initial begin
    {arst_n, regWr, regRd, raise, enIn} = '0;
    {emuAttached, emuRunReq, emuPcWrReq} = '0;
    clkEn     = 1'b1;
    regAddr   = 16'h0000;
    regWrData = 32'h0000_0000;
    void'($urandom(32'hfdf7));
    do_reset();
    #1 `CHK({cpuClkEn, pllOutStop, pllInStop}, 3'b100)
    stop_test(PDMC_CODE_PLL_IN);
    stop_test(PDMC_CODE_PLL_OUT);
    for (int i = 0; i < 4; i++) begin
      wr(16'h0000, codes[i/2]);
      n = 0;
      while (cpuClkEn !== 1'b0 && n < 20) begin
        @(posedge clk_sys);
        #1 n++;
      end
      `CHK(n inside {8, 9}, 1'b1)
      `CHK({intLogicClkEn, dmaClkEn}, 2'b11)
      irq(i[0]);
      `CHK(woke, wakes(codes[i/2], i[0]))
      `CHK(isr, woke & i[0])
      if (!woke) begin
        irq(1'b1);
        `CHK({woke, isr}, 2'b11)
      end
    end
    // random reserved codes; bit 15 of the field always written as zero
    repeat (6) begin
      f = 6'($urandom_range(1, 31));
      if (f inside {PDMC_CODE_GATE_EN, PDMC_CODE_GATE_ANY,
                    PDMC_CODE_PLL_OUT, PDMC_CODE_PLL_IN}) f = 6'h01;
      wr(16'h0000, f);
      rd(16'h0000);
      `CHK(d[15:10], f)
      repeat (12) @(posedge clk_sys);
      #1 `CHK({cpuClkEn, pllOutStop, pllInStop}, 3'b100)
    end
    // clock enable low freezes the entry delay right after it starts
    wr(16'h0000, PDMC_CODE_GATE_ANY);
    clkEn <= 1'b0;
    repeat (12) @(posedge clk_sys);
    #1 `CHK(cpuClkEn, 1'b1)
    @(posedge clk_sys);
    clkEn <= 1'b1;
    n = 0;
    while (cpuClkEn !== 1'b0 && n < 20) begin
      @(posedge clk_sys);
      #1 n++;
    end
    `CHK(n inside {8, 9}, 1'b1)
    irq(1'b0);
    `CHK({woke, isr}, 2'b10)
    wr(16'h0004, PDMC_CODE_GATE_EN);
    rd(16'h0004);
    `CHK(d, 32'h0000_0000)
    repeat (12) @(posedge clk_sys);
    #1 `CHK(cpuClkEn, 1'b1)
    @(posedge clk_sys);
    emuAttached <= 1'b1;
    wr(16'h0000, PDMC_CODE_GATE_ANY);
    repeat (12) @(posedge clk_sys);
    #1 `CHK(cpuClkEn, 1'b1)
    wr(16'h0000, 6'h00);
    emuAttached <= 1'b0;
    test_done();
  end
endmodule
